/* File: verilog/eif_pkg.sv */
// ************************************************************
// Shared constants for the enable gating and frame index block
// ************************************************************
package eif_pkg;
  // Register port address width
  localparam int ADDR_W = 8;
  // Byte offsets of the two registers
  localparam logic [7:0] INT_ENABLE_OFFSET = 8'h28;
  localparam logic [7:0] FRAME_INDEX_OFFSET = 8'h2c;
  // Reset values
  localparam logic [5:0] INT_ENABLE_RESET = 6'h00;
  localparam logic [13:0] FRAME_INDEX_RESET = 14'h0000;
  // Enable and flag bit positions, shared by both registers
  localparam int IRQ_BIT_ASYNC = 5;
  localparam int IRQ_BIT_SYSERR = 4;
  localparam int IRQ_BIT_ROLLOVER = 3;
  localparam int IRQ_BIT_PORT = 2;
  localparam int IRQ_BIT_XACTERR = 1;
  localparam int IRQ_BIT_DONE = 0;
  localparam int IRQ_SRC_N = 6;
  // Sources that bypass the threshold, and those that wait for it
  localparam logic [5:0] IMMEDIATE_MASK = 6'h1c;
  localparam logic [5:0] DEFERRED_MASK = 6'h23;
  // Outside register fields that this block watches
  localparam int STATUS_HALTED_BIT = 12;
  localparam int CMD_RUN_STOP_BIT = 0;
  localparam int CMD_LIST_SIZE_LSB = 2;
  // Frame index geometry
  localparam int FRAME_INDEX_W = 14;
  localparam int LIST_INDEX_W = 10;
  localparam int SOF_LSB = 3;
  // Rollover masks: low N+1 index bits all ones
  localparam logic [13:0] ROLL_MASK_1024 = 14'h1fff;
  localparam logic [13:0] ROLL_MASK_512 = 14'h0fff;
  localparam logic [13:0] ROLL_MASK_256 = 14'h07ff;
  // Microframe timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int UFRAME_NS = 125000;
  localparam int UFRAME_CYCLES = UFRAME_NS / CLK_PERIOD_NS;
  localparam int UFRAME_CNT_W = 11;
  // Frame list size codes
  typedef enum logic [1:0] {
    LIST_1024 = 2'b00,
    LIST_512 = 2'b01,
    LIST_256 = 2'b10,
    LIST_RSVD = 2'b11
  } eif_list_size_e;
  // Interrupt output states
  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_WAIT = 2'b01,
    IRQ_ASSERT = 2'b10
  } eif_irq_state_e;
endpackage

/* File: verilog/eif_uframe_timer.sv */
// ************************************************************
// Microframe divider: one-cycle tick per 125 us while running
// ************************************************************
module eif_uframe_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);
  import eif_pkg::*;
  // Cycle counter within the current microframe
  logic [UFRAME_CNT_W-1:0] cnt_reg;
  logic [UFRAME_CNT_W-1:0] cnt_next;
  localparam logic [UFRAME_CNT_W-1:0] LAST = UFRAME_CNT_W'(UFRAME_CYCLES - 1);

  // Next count; restart from zero whenever the schedule stops
  always_comb begin
    cnt_next = cnt_reg;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg == LAST) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  // Register only
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Tick on the last cycle of each microframe
  assign tick = run && (cnt_reg == LAST);
endmodule

/* File: verilog/eif_irq_frame_index.sv */
// Summary of operation
// - Interrupt only when enable and flag both set
// - Disabled sources still flag; only output suppressed
// - Async advance interrupt waits for threshold
// - Host system error interrupts immediately
// - Frame list rollover interrupts immediately
// - Port change interrupts immediately
// - Transaction error interrupt waits for threshold
// - Transfer complete interrupt waits for threshold
// - Clearing flag drops that source's request
// - Frame index advances every 125 us running
// - Index bits N..3 select list entry
// - Size code gives N of 12, 11, 10
// - Frame index writable only while halted
// - SOF frame number taken from frame index
module eif_irq_frame_index (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [eif_pkg::ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic [3:0] regByteEn,
  output logic [31:0] regRdData,
  input wire logic [31:0] statusReg,
  input wire logic [31:0] commandReg,
  input wire logic thresholdTick,
  output logic hostIrq,
  output logic [eif_pkg::FRAME_INDEX_W-1:0] frameIndex,
  output logic [eif_pkg::LIST_INDEX_W-1:0] frameListIndex,
  output logic [10:0] sofFrameNumber,
  output logic listRollover,
  output logic uframeTick
);
  import eif_pkg::*;
  // ************************************************************
  // Decode of outside fields
  // ************************************************************
  logic [5:0] statusFlags; // Six flags gated by the enables
  logic haltedFlag; // Controller stopped
  logic runStop; // Schedule enabled by software
  eif_list_size_e listSize; // Frame list size code
  assign statusFlags = statusReg[IRQ_SRC_N-1:0];
  assign haltedFlag = statusReg[STATUS_HALTED_BIT];
  assign runStop = commandReg[CMD_RUN_STOP_BIT];
  assign listSize = eif_list_size_e'(commandReg[CMD_LIST_SIZE_LSB +: 2]);

  // Register port decode
  logic wrEnable; // Enable register write, low byte carries all fields
  logic wrIndex; // Accepted frame index write
  assign wrEnable = regWrEn && (regAddr == INT_ENABLE_OFFSET) && regByteEn[0];
  // Partial writes are dropped: only a full word is defined
  assign wrIndex = regWrEn && (regAddr == FRAME_INDEX_OFFSET) && (regByteEn == 4'hf)
    && haltedFlag;

  // ************************************************************
  // Interrupt enable register
  // ************************************************************
  logic [5:0] enable_reg;
  logic [5:0] enable_next;

  // Reserved bits are not stored and read back zero
  always_comb begin
    enable_next = enable_reg;
    if (wrEnable) begin
      enable_next = regWrData[IRQ_SRC_N-1:0];
    end
  end

  // Register only
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= INT_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // ************************************************************
  // Interrupt gating
  // ************************************************************
  // Enables only mask the output; flags are untouched here
  logic [5:0] gated; // One gate per source
  logic immCause; // Sources that skip the threshold
  logic defCause; // Sources that wait for the threshold
  generate
    for (genvar gi = 0; gi < IRQ_SRC_N; gi++) begin : g_gate
      assign gated[gi] = enable_reg[gi] && statusFlags[gi];
    end
  endgenerate
  assign immCause = |(gated & IMMEDIATE_MASK);
  assign defCause = |(gated & DEFERRED_MASK);

  eif_irq_state_e irqState_reg;
  eif_irq_state_e irqState_next;

  // Output state; once raised, a deferred source keeps it up until cleared
  always_comb begin
    irqState_next = irqState_reg;
    case (irqState_reg)
      IRQ_IDLE: begin
        if (immCause || (defCause && thresholdTick)) begin
          irqState_next = IRQ_ASSERT;
        end else if (defCause) begin
          irqState_next = IRQ_WAIT;
        end
      end
      IRQ_WAIT: begin
        if (immCause || (defCause && thresholdTick)) begin
          irqState_next = IRQ_ASSERT;
        end else if (!defCause) begin
          irqState_next = IRQ_IDLE; // Acknowledged before threshold
        end
      end
      IRQ_ASSERT: begin
        if (!immCause && !defCause) begin
          irqState_next = IRQ_IDLE; // All flags cleared
        end
      end
      default: begin
        irqState_next = IRQ_IDLE;
      end
    endcase
  end

  // Register only
  always_ff @(posedge clk) begin
    if (rst) begin
      irqState_reg <= IRQ_IDLE;
    end else begin
      irqState_reg <= irqState_next;
    end
  end

  // Straight decode of a flop, so no glitch reaches the host
  assign hostIrq = (irqState_reg == IRQ_ASSERT);

  // ************************************************************
  // Microframe timing and frame index
  // ************************************************************
  logic running; // Schedule actually executing
  assign running = runStop && !haltedFlag;

  // One tick per microframe while running
  eif_uframe_timer u_timer (
    .clk(clk),
    .rst(rst),
    .run(running),
    .tick(uframeTick)
  );

  logic [13:0] index_reg;
  logic [13:0] index_next;
  logic roll_reg;
  logic roll_next;
  logic [13:0] rollMask; // Low N+1 bits for the list size

  // Reserved size code is treated as the largest list
  always_comb begin
    case (listSize)
      LIST_512: rollMask = ROLL_MASK_512;
      LIST_256: rollMask = ROLL_MASK_256;
      default: rollMask = ROLL_MASK_1024;
    endcase
  end

  // Write while halted, else count microframes
  always_comb begin
    index_next = index_reg;
    roll_next = 1'b0;
    if (wrIndex) begin
      index_next = regWrData[FRAME_INDEX_W-1:0];
    end else if (uframeTick) begin
      index_next = index_reg + 14'h0001; // Wraps 3fff to 0
      roll_next = ((index_reg & rollMask) == rollMask);
    end
  end

  // Register only
  always_ff @(posedge clk) begin
    if (rst) begin
      index_reg <= FRAME_INDEX_RESET;
      roll_reg <= 1'b0;
    end else begin
      index_reg <= index_next;
      roll_reg <= roll_next;
    end
  end

  assign frameIndex = index_reg;
  assign listRollover = roll_reg;
  assign sofFrameNumber = index_reg[FRAME_INDEX_W-1:SOF_LSB];

  // List entry from bits N..3
  always_comb begin
    case (listSize)
      LIST_512: frameListIndex = {1'b0, index_reg[11:SOF_LSB]};
      LIST_256: frameListIndex = {2'b00, index_reg[10:SOF_LSB]};
      default: frameListIndex = index_reg[12:SOF_LSB];
    endcase
  end

  // ************************************************************
  // Read data
  // ************************************************************
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;

  // Unmapped offsets read zero
  always_comb begin
    rdData_next = rdData_reg;
    if (regRdEn) begin
      case (regAddr)
        INT_ENABLE_OFFSET: rdData_next = {26'h0, enable_reg};
        FRAME_INDEX_OFFSET: rdData_next = {18'h0, index_reg};
        default: rdData_next = 32'h00000000;
      endcase
    end
  end

  // Register only
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= 32'h00000000;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_irqNeedsCause;
    hostIrq |-> $past(immCause || defCause);
  endproperty
  a_irqNeedsCause: assert property (p_irqNeedsCause)
    else $error("interrupt raised with no enabled flag");
  property p_disabledSilent;
    (enable_reg == 6'h00) |=> !hostIrq;
  endproperty
  a_disabledSilent: assert property (p_disabledSilent)
    else $error("interrupt raised with all enables clear");
  property p_deferredWaits;
    (!hostIrq && !thresholdTick && !immCause) |=> !hostIrq;
  endproperty
  a_deferredWaits: assert property (p_deferredWaits)
    else $error("deferred source raised interrupt before threshold");
  property p_immediate;
    immCause |=> hostIrq;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("immediate source did not raise interrupt");
  property p_atThreshold;
    (defCause && thresholdTick) |=> hostIrq;
  endproperty
  a_atThreshold: assert property (p_atThreshold)
    else $error("deferred source missed threshold");
  property p_ackDrops;
    (gated == 6'h00) |=> !hostIrq;
  endproperty
  a_ackDrops: assert property (p_ackDrops)
    else $error("interrupt held after flags cleared");
  property p_advance;
    (uframeTick && !wrIndex) |=> (frameIndex == $past(frameIndex) + 14'h0001);
  endproperty
  a_advance: assert property (p_advance)
    else $error("frame index did not advance by one");
  property p_holdBetween;
    (!uframeTick && !wrIndex) |=> $stable(frameIndex);
  endproperty
  a_holdBetween: assert property (p_holdBetween)
    else $error("frame index moved between microframes");
  property p_writeWhileRunning;
    (regWrEn && (regAddr == FRAME_INDEX_OFFSET) && !haltedFlag && !uframeTick)
      |=> $stable(frameIndex);
  endproperty
  a_writeWhileRunning: assert property (p_writeWhileRunning)
    else $error("frame index written while not halted");
  property p_writeToSof;
    wrIndex |=> (sofFrameNumber == $past(regWrData[13:3]));
  endproperty
  a_writeToSof: assert property (p_writeToSof)
    else $error("SOF number not taken from written index");
  property p_list512;
    (listSize == LIST_512) |-> (frameListIndex == {1'b0, frameIndex[11:3]});
  endproperty
  a_list512: assert property (p_list512)
    else $error("list entry wrong for 512 entries");
endmodule

/* File: verification/eif_irq_frame_index_tb_top.sv */
// ************************************************************
// Bench for enable gating and frame index counting
// ************************************************************
module eif_irq_frame_index_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import eif_pkg::*;

  // Stimulus, all but clk driven by non-blocking assignment at posedge
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [ADDR_W-1:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic [3:0] regByteEn = 4'h0;
  logic [31:0] statusReg = 32'h00001000; // Starts halted
  logic [31:0] commandReg = 32'h0;
  logic thresholdTick = 1'b0;
  // Observed outputs
  logic [31:0] regRdData;
  logic hostIrq;
  logic [FRAME_INDEX_W-1:0] frameIndex;
  logic [LIST_INDEX_W-1:0] frameListIndex;
  logic [10:0] sofFrameNumber;
  logic listRollover;
  logic uframeTick;
  // Score keeping
  int fails = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [31:0] rd;

  eif_irq_frame_index u_dut (
    .clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regByteEn(regByteEn), .regRdData(regRdData),
    .statusReg(statusReg), .commandReg(commandReg), .thresholdTick(thresholdTick),
    .hostIrq(hostIrq), .frameIndex(frameIndex), .frameListIndex(frameListIndex),
    .sofFrameNumber(sofFrameNumber), .listRollover(listRollover), .uframeTick(uframeTick)
  );

  // 10 MHz clock
  always #50 clk = ~clk;

  // Hang guard: whole run needs about 8000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Four-state compare, so X never passes
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    testsRun = testsRun + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One-cycle write strobe; effective at the strobe's edge
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    regByteEn <= be;
    @(posedge clk);
    regWrEn <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; data registered at that edge
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // Bounded wait for the interrupt level
  task automatic waitIrq(input logic exp, input int maxc);
    for (int i = 0; i < maxc; i++) begin
      @(posedge clk);
      #1;
      if (hostIrq === exp) break;
    end
  endtask

  // Single-cycle threshold pulse
  task automatic pulseThreshold();
    @(posedge clk);
    thresholdTick <= 1'b1;
    @(posedge clk);
    thresholdTick <= 1'b0;
  endtask

  // Run or halt the schedule
  task automatic setRun(input logic run);
    @(posedge clk);
    commandReg[0] <= run;
    statusReg[12] <= ~run;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic testRegs();
    regRead(INT_ENABLE_OFFSET, rd);
    check(rd, 32'h0, "enable reset");
    regRead(FRAME_INDEX_OFFSET, rd);
    check(rd, 32'h0, "index reset");
    check(hostIrq, 1'b0, "irq reset");
    // Reserved bits kept at zero, as software must
    regWrite(INT_ENABLE_OFFSET, 32'h0000003f, 4'hf);
    regRead(INT_ENABLE_OFFSET, rd);
    check(rd, 32'h3f, "enable write");
    // Low byte disabled: write must not land
    regWrite(INT_ENABLE_OFFSET, 32'h0, 4'he);
    regRead(INT_ENABLE_OFFSET, rd);
    check(rd, 32'h3f, "enable partial write");
    regRead(8'h30, rd);
    check(rd, 32'h0, "unmapped read");
    regWrite(INT_ENABLE_OFFSET, 32'h0, 4'hf);
    $display("TEST done: regs");
  endtask

  // Each source alone; deferred ones must hold off until the threshold
  task automatic testSources();
    logic [5:0] m;
    for (int b = 0; b < IRQ_SRC_N; b++) begin
      m = 6'h01 << b;
      regWrite(INT_ENABLE_OFFSET, {26'h0, m}, 4'hf);
      @(posedge clk);
      statusReg[5:0] <= m;
      if (IMMEDIATE_MASK[b]) begin
        waitIrq(1'b1, 3);
        check(hostIrq, 1'b1, "immediate irq");
      end else begin
        waitIrq(1'b1, 20);
        check(hostIrq, 1'b0, "deferred early");
        pulseThreshold();
        waitIrq(1'b1, 3);
        check(hostIrq, 1'b1, "deferred at threshold");
      end
      repeat (5) @(posedge clk);
      #1;
      check(hostIrq, 1'b1, "irq holds");
      @(posedge clk);
      statusReg[5:0] <= 6'h00;
      waitIrq(1'b0, 3);
      check(hostIrq, 1'b0, "ack clears");
      // Every other source enabled, only this one flagging
      regWrite(INT_ENABLE_OFFSET, {26'h0, ~m}, 4'hf);
      @(posedge clk);
      statusReg[5:0] <= m;
      pulseThreshold();
      waitIrq(1'b1, 6);
      check(hostIrq, 1'b0, "masked source");
      @(posedge clk);
      statusReg[5:0] <= 6'h00;
    end
    regWrite(INT_ENABLE_OFFSET, 32'h0, 4'hf);
    $display("TEST done: sources");
  endtask

  // Halted writes, list index per size code, refused write when not halted
  task automatic testIndexWrite();
    logic [9:0] expList [4] = '{10'h3ff, 10'h1ff, 10'h0ff, 10'h3ff};
    regWrite(FRAME_INDEX_OFFSET, 32'h00003ff8, 4'hf);
    check(frameIndex, 14'h3ff8, "index write");
    check(sofFrameNumber, 11'h7ff, "sof number");
    regRead(FRAME_INDEX_OFFSET, rd);
    check(rd, 32'h3ff8, "index readback");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      commandReg[3:2] <= s[1:0];
      @(posedge clk);
      #1;
      check(frameListIndex, expList[s], "list index");
    end
    @(posedge clk);
    commandReg[3:2] <= 2'b00;
    statusReg[12] <= 1'b0;
    regWrite(FRAME_INDEX_OFFSET, 32'h0123, 4'hf);
    check(frameIndex, 14'h3ff8, "write not halted");
    @(posedge clk);
    statusReg[12] <= 1'b1;
    $display("TEST done: index write");
  endtask

  // Wait for a tick and return cycles spent
  task automatic waitTick(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (uframeTick !== 1'b1 && n < 1400);
  endtask

  task automatic testCount();
    int n;
    regWrite(FRAME_INDEX_OFFSET, 32'h1fff, 4'hf);
    setRun(1'b1);
    waitTick(n);
    @(posedge clk);
    #1;
    check(frameIndex, 14'h2000, "increment");
    check(listRollover, 1'b1, "rollover 1024");
    waitTick(n);
    // One edge of this period was spent reading the index
    check(n + 1, UFRAME_CYCLES, "tick period");
    setRun(1'b0);
    regWrite(FRAME_INDEX_OFFSET, 32'h3fff, 4'hf);
    waitTick(n);
    check(frameIndex, 14'h3fff, "no count halted");
    setRun(1'b1);
    waitTick(n);
    @(posedge clk);
    #1;
    check(frameIndex, 14'h0000, "wrap");
    check(sofFrameNumber, 11'h000, "sof follows");
    setRun(1'b0);
    // Smaller lists roll over at their own, lower boundary
    for (int s = 1; s < 3; s++) begin
      @(posedge clk);
      commandReg[3:2] <= s[1:0];
      regWrite(FRAME_INDEX_OFFSET, 32'h00001fff >> s, 4'hf);
      setRun(1'b1);
      waitTick(n);
      @(posedge clk);
      #1;
      check(listRollover, 1'b1, "rollover small list");
      setRun(1'b0);
    end
    @(posedge clk);
    commandReg[3:2] <= 2'b00;
    $display("TEST done: count");
  endtask

  // Verdict, the only exit
  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    testRegs();
    testSources();
    testIndexWrite();
    testCount();
    summarize();
  end
endmodule
